//--- hdl/dart_pkg.sv
// Constants and types shared by the dual autoreload timer
`default_nettype none
package dart_pkg;
	localparam int          CNT_W   = 12;
	localparam int          NUM_CH  = 4;
	localparam logic [11:0] CNT_MAX = 12'hFFF;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CSR1   = 6'h0D;
	localparam logic [5:0] IDX_CNT1H  = 6'h0E;
	localparam logic [5:0] IDX_CNT1L  = 6'h0F;
	localparam logic [5:0] IDX_ATR1H  = 6'h10;
	localparam logic [5:0] IDX_ATR1L  = 6'h11;
	localparam logic [5:0] IDX_OCR    = 6'h12;
	localparam logic [5:0] IDX_CHCSR0 = 6'h13;
	localparam logic [5:0] IDX_DUTY0H = 6'h17;
	localparam logic [5:0] IDX_CSR2   = 6'h21;
	localparam logic [5:0] IDX_RELOAD_TWO_HIGH  = 6'h22;
	localparam logic [5:0] IDX_RELOAD_TWO_LOW  = 6'h23;
	localparam logic [5:0] IDX_DTG    = 6'h24;

	// Field positions
	localparam int CSR1_CK_LO = 3;
	localparam int CSR1_OVF   = 2;
	localparam int CSR1_OVFIE = 1;
	localparam int CSR1_CMPIE = 0;
	localparam int CSR2_OVFIE = 4;
	localparam int CSR2_OVF   = 3;
	localparam int CSR2_RUN   = 2;
	localparam int CSR2_TRANSFER_ENABLE_TWO = 1;
	localparam int CSR2_TRANSFER_ENABLE_ONE = 0;
	localparam int CHCSR_POL  = 1;
	localparam int CHCSR_CMPF = 0;
	localparam int DTG_EN     = 7;

	// Values after reset
	localparam logic [7:0]  REG_RST  = 8'h00;
	localparam logic [1:0]  TRAN_RST = 2'h3;
	localparam logic [11:0] CNT_RST  = 12'h000;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} dart_apb_req_t;

	typedef struct packed {
		logic [11:0]           cnt1;
		logic [11:0]           cnt2;
		logic [11:0]           atr1;
		logic [11:0]           second_reload_value;
		logic [3:0][11:0]      duty_pre;
		logic [3:0][11:0]      duty_act;
		logic [3:0]            oe;
		logic [3:0]            pol;
		logic [3:0]            pol_sh;
		logic [3:0]            cmpf;
		logic                  ovf1;
		logic                  ovfie1;
		logic                  cmpie;
		logic [1:0]            clk_sel;
		logic                  overflow_irq_enable_two;
		logic                  overflow_flag_two;
		logic                  run2;
		logic                  transfer_enable_two;
		logic                  transfer_enable_one;
		logic [7:0]            dtg;
		logic [7:0]            rdata;
	} dart_state_t;

	typedef struct packed {
		logic lvl;
	} dart_chan_t;

	typedef struct packed {
		logic [6:0] cnt;
		logic       lvl;
		logic       out;
	} dart_dead_t;
endpackage
`default_nettype wire

//--- hdl/dart_chan.sv
// One compare channel: set on overflow, clear on duty match
`default_nettype none
module dart_chan
	import dart_pkg::*;
(
	input  wire logic              ref_clk,  // Counter clock
	input  wire logic              rst,      // Sync reset
	input  wire logic              ovf,      // Overflow of driving counter
	input  wire logic [CNT_W-1:0]  cnt,      // Driving counter value
	input  wire logic [CNT_W-1:0]  duty,     // Active duty value
	input  wire logic              pol_sh,   // Shadow polarity
	output logic                   match,    // Counter equals duty
	output logic                   level     // Polarity-corrected level
);
	dart_chan_t s_r;
	dart_chan_t s_nxt;

	assign match = (cnt == duty);
	// Low already in the match cycle, so high time is duty minus reload
	assign level = (s_r.lvl & ~match) ^ pol_sh; // R09

	always_comb
	begin
		s_nxt = s_r;
		// Overflow wins over a match in the same cycle
		if (ovf)
			s_nxt.lvl = 1'b1; // R06
		else if (match)
			s_nxt.lvl = 1'b0; // R06
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

//--- hdl/dart_dead.sv
// Rising-edge delay for dead time, with output enable gating
`default_nettype none
module dart_dead
	import dart_pkg::*;
#(
	parameter int DT_W = 7
)
(
	input  wire logic            ref_clk, // Counter clock
	input  wire logic            rst,     // Sync reset
	input  wire logic            din,     // Channel level
	input  wire logic            dt_en,   // Insert dead time
	input  wire logic [DT_W-1:0] dt_val,  // Dead time in counter ticks
	input  wire logic            oe,      // Output enable
	output logic                 dout     // Registered pin level
);
	dart_dead_t s_r;
	dart_dead_t s_nxt;

	generate
		if (DT_W < 1 || DT_W > 7)
		begin : g_bad
			$error("dart_dead: DT_W must be 1..7");
		end
	endgenerate

	assign dout = s_r.out;

	always_comb
	begin
		s_nxt = s_r;
		if (!dt_en || !din)
		begin
			s_nxt.cnt = '0;
			s_nxt.lvl = din;
		end
		else if (s_r.cnt[DT_W-1:0] == dt_val)
			s_nxt.lvl = 1'b1; // R17
		else
			s_nxt.cnt = s_r.cnt + 7'h01; // R16
		s_nxt.out = oe & s_nxt.lvl; // R10
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

//--- hdl/dart_top.sv
// Dual 12-bit autoreload PWM timer with APB register slave
//
// Functional notes
// R01 - Counter two drives outputs two, three
// R02 - Period is 4096 minus reload value
// R03 - Duty preloads copied only on overflow
// R04 - Each transfer bit governs its counter
// R05 - Counter one starts from zero
// R06 - Overflow sets output, duty match clears
// R07 - Software keeps duty above reload value
// R08 - Software keeps reload at most 4094
// R09 - Shadow polarity inverts, updated like duty
// R10 - Per-output enable bit gates pin
// R11 - Control two bit 4 enables interrupt
// R12 - Overflow two flag, cleared by read
// R13 - Control two bit 2 runs counter two
// R14 - Transfer bits set at reset, self-clear
// R15 - Counter two reloads from its reload
// R16 - Dead-time enable on outputs zero, one
// R17 - Dead time is value times tick
// R18 - Counter one reloads and flags overflow
//
// Design decision made here: the APB register port.
`default_nettype none
module dart_top
	import dart_pkg::*;
(
	input  wire logic          ref_clk,      // 50 MHz counter clock
	input  wire logic          rst,          // Sync reset, active high
	input  wire dart_apb_req_t apb_req,      // APB request group
	output logic [31:0]        prdata,       // APB read data
	output logic               pready,       // APB ready
	output logic               pslverr,      // Unmapped access
	output logic [3:0]         pulse_output, // PWM pins
	output logic               irq_one,      // Counter one interrupt
	output logic               irq_two       // Counter two interrupt
);
	dart_state_t s_r;
	dart_state_t s_nxt;

	logic [3:0]             match;
	logic [3:0]             level;
	logic [3:0]             ch_ovf;
	logic [3:0][CNT_W-1:0]  ch_cnt;
	logic                   ovf1_ev;
	logic                   overflow_flag_two_ev;
	logic [5:0]             idx;
	logic                   setup_ph;
	logic                   access_ph;
	logic                   wr_acc;
	logic                   rd_acc;
	logic [7:0]             wdat;

	// Outputs two and three move to counter two in dual mode
	function automatic logic on_two(input int ch, input logic run2);
		on_two = (ch >= 2) && run2; // R01
	endfunction

	function automatic logic is_mapped(input logic [5:0] i);
		is_mapped = ((i >= IDX_CSR1) && (i <= 6'h1E))
			|| ((i >= IDX_CSR2) && (i <= IDX_DTG));
	endfunction

	function automatic logic [7:0] read_mux(input dart_state_t s, input logic [5:0] i);
		logic [5:0] off;
		off = i - IDX_DUTY0H;
		read_mux = 8'h00;
		case (i)
			IDX_CSR1:  read_mux = {3'h0, s.clk_sel, s.ovf1, s.ovfie1, s.cmpie};
			IDX_CNT1H: read_mux = {4'h0, s.cnt1[11:8]};
			IDX_CNT1L: read_mux = s.cnt1[7:0];
			IDX_ATR1H: read_mux = {4'h0, s.atr1[11:8]};
			IDX_ATR1L: read_mux = s.atr1[7:0];
			IDX_OCR:   read_mux = {1'b0, s.oe[3], 1'b0, s.oe[2], 1'b0, s.oe[1], 1'b0, s.oe[0]};
			IDX_CSR2:  read_mux = {3'h0, s.overflow_irq_enable_two, s.overflow_flag_two, s.run2, s.transfer_enable_two, s.transfer_enable_one};
			IDX_RELOAD_TWO_HIGH: read_mux = {4'h0, s.second_reload_value[11:8]};
			IDX_RELOAD_TWO_LOW: read_mux = s.second_reload_value[7:0];
			IDX_DTG:   read_mux = s.dtg;
			default:
			begin
				if ((i >= IDX_CHCSR0) && (i < IDX_DUTY0H))
					read_mux = {6'h00, s.pol[i[1:0] + 2'h1], s.cmpf[i[1:0] + 2'h1]};
				else if (off < 6'h08)
				begin
					if (!off[0])
						read_mux = {4'h0, s.duty_pre[off[2:1]][11:8]};
					else
						read_mux = s.duty_pre[off[2:1]][7:0];
				end
			end
		endcase
	endfunction

	assign idx       = apb_req.paddr[7:2];
	assign setup_ph  = apb_req.psel & ~apb_req.penable;
	assign access_ph = apb_req.psel & apb_req.penable;
	assign wr_acc    = access_ph & apb_req.pwrite & is_mapped(idx);
	assign rd_acc    = access_ph & ~apb_req.pwrite & is_mapped(idx);
	assign wdat      = apb_req.pwdata[7:0];

	// Read data is captured in setup so the access phase needs no wait
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~is_mapped(idx);
	assign prdata  = {24'h000000, s_r.rdata};

	assign irq_one = (s_r.ovf1 & s_r.ovfie1) | (s_r.cmpie & (|s_r.cmpf));
	assign irq_two = s_r.overflow_flag_two & s_r.overflow_irq_enable_two; // R11

	// Overflow is the cycle at the top count; the reload follows it
	assign ovf1_ev = (s_r.cnt1 == CNT_MAX); // R18
	assign overflow_flag_two_ev = s_r.run2 & (s_r.cnt2 == CNT_MAX); // R13

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			assign ch_ovf[g] = on_two(g, s_r.run2) ? overflow_flag_two_ev : ovf1_ev; // R01
			assign ch_cnt[g] = on_two(g, s_r.run2) ? s_r.cnt2 : s_r.cnt1;

			dart_chan u_chan
			(
				.ref_clk (ref_clk),
				.rst     (rst),
				.ovf     (ch_ovf[g]),
				.cnt     (ch_cnt[g]),
				.duty    (s_r.duty_act[g]),
				.pol_sh  (s_r.pol_sh[g]),
				.match   (match[g]),
				.level   (level[g])
			);

			dart_dead #(.DT_W(7)) u_dead
			(
				.ref_clk (ref_clk),
				.rst     (rst),
				.din     (level[g]),
				.dt_en   (s_r.dtg[DTG_EN] && (g < 2)), // R16
				.dt_val  (s_r.dtg[6:0]),
				.oe      (s_r.oe[g]),
				.dout    (pulse_output[g])
			);
		end
	endgenerate

	always_comb
	begin
		logic [5:0] off;
		logic       xfer1;
		logic       xfer2;
		logic       do_x;
		off   = idx - IDX_DUTY0H;
		xfer1 = ovf1_ev & s_r.transfer_enable_one; // R04
		xfer2 = overflow_flag_two_ev & s_r.transfer_enable_two; // R04
		do_x  = 1'b0;
		s_nxt = s_r;

		// Counters: period is 4096 minus the reload value
		if (ovf1_ev)
			s_nxt.cnt1 = s_r.atr1; // R02
		else
			s_nxt.cnt1 = s_r.cnt1 + 12'h001; // R18
		if (s_r.run2)
		begin
			if (overflow_flag_two_ev)
				s_nxt.cnt2 = s_r.second_reload_value; // R15
			else
				s_nxt.cnt2 = s_r.cnt2 + 12'h001; // R13
		end

		// Preload to active transfer, shadow polarity alongside
		for (int i = 0; i < NUM_CH; i++)
		begin
			do_x = on_two(i, s_r.run2) ? xfer2 : xfer1; // R04
			if (do_x)
			begin
				s_nxt.duty_act[i] = s_r.duty_pre[i]; // R03
				s_nxt.pol_sh[i]   = s_r.pol[i]; // R09
			end
		end
		if (xfer1)
			s_nxt.transfer_enable_one = 1'b0; // R14
		if (xfer2)
			s_nxt.transfer_enable_two = 1'b0; // R14

		// Clear-on-read first, so a same-cycle event still sets
		if (rd_acc)
		begin
			if (idx == IDX_CSR1)
				s_nxt.ovf1 = 1'b0;
			if (idx == IDX_CSR2)
				s_nxt.overflow_flag_two = 1'b0; // R12
			if ((idx >= IDX_CHCSR0) && (idx < IDX_DUTY0H))
				s_nxt.cmpf[idx[1:0] + 2'h1] = 1'b0;
		end
		if (ovf1_ev)
			s_nxt.ovf1 = 1'b1; // R18
		if (overflow_flag_two_ev)
			s_nxt.overflow_flag_two = 1'b1; // R12
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (match[i])
				s_nxt.cmpf[i] = 1'b1;
		end

		if (setup_ph)
			s_nxt.rdata = read_mux(s_r, idx);

		// Software writes last; a written set wins over the hardware clear
		if (wr_acc)
		begin
			case (idx)
				IDX_CSR1:
				begin
					s_nxt.clk_sel = wdat[CSR1_CK_LO+1:CSR1_CK_LO];
					s_nxt.ovfie1  = wdat[CSR1_OVFIE];
					s_nxt.cmpie   = wdat[CSR1_CMPIE];
				end
				IDX_ATR1H: s_nxt.atr1[11:8] = wdat[3:0];
				IDX_ATR1L: s_nxt.atr1[7:0]  = wdat;
				IDX_OCR:
				begin
					for (int i = 0; i < NUM_CH; i++)
						s_nxt.oe[i] = wdat[2*i]; // R10
				end
				IDX_CSR2:
				begin
					s_nxt.overflow_irq_enable_two = wdat[CSR2_OVFIE]; // R11
					s_nxt.run2   = wdat[CSR2_RUN]; // R13
					s_nxt.transfer_enable_two  = wdat[CSR2_TRANSFER_ENABLE_TWO]; // R14
					s_nxt.transfer_enable_one  = wdat[CSR2_TRANSFER_ENABLE_ONE]; // R14
				end
				IDX_RELOAD_TWO_HIGH: s_nxt.second_reload_value[11:8] = wdat[3:0]; // R15
				IDX_RELOAD_TWO_LOW: s_nxt.second_reload_value[7:0]  = wdat; // R15
				IDX_DTG:   s_nxt.dtg        = wdat; // R16
				default:
				begin
					if ((idx >= IDX_CHCSR0) && (idx < IDX_DUTY0H))
						s_nxt.pol[idx[1:0] + 2'h1] = wdat[CHCSR_POL]; // R09
					else if (off < 6'h08)
					begin
						if (!off[0])
							s_nxt.duty_pre[off[2:1]][11:8] = wdat[3:0]; // R03
						else
							s_nxt.duty_pre[off[2:1]][7:0] = wdat; // R03
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_r       <= '0;
			s_r.cnt1  <= CNT_RST; // R05
			s_r.cnt2  <= CNT_RST;
			s_r.transfer_enable_two <= TRAN_RST[1]; // R14
			s_r.transfer_enable_one <= TRAN_RST[0]; // R14
		end
		else
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

//--- sim/dart_top_checker.sv
// Port assertions for the dual autoreload timer
`default_nettype none
module dart_top_checker
	import dart_pkg::*;
(
	input wire logic          ref_clk,      // Counter clock
	input wire logic          rst,          // Sync reset
	input wire dart_apb_req_t apb_req,      // APB request
	input wire logic [31:0]   prdata,       // Read data
	input wire logic          pready,       // Ready
	input wire logic          pslverr,      // Error
	input wire logic [3:0]    pulse_output, // Pins
	input wire logic          irq_one,      // Interrupt one
	input wire logic          irq_two       // Interrupt two
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [5:0] idx;
	logic       acc;
	logic       wr;
	logic       mapped;
	logic [3:0] oe_q;
	logic [2:0] ie_q;
	assign idx = apb_req.paddr[7:2];
	assign acc = apb_req.psel && apb_req.penable && pready;
	assign wr = acc && apb_req.pwrite;
	assign mapped = (idx >= IDX_CSR1 && idx <= 6'h1E) || (idx >= IDX_CSR2 && idx <= IDX_DTG);
	// Shadows of enables, snooped from writes
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			oe_q <= 4'h0;
			ie_q <= 3'h0;
		end
		else
		begin
			if (wr && idx == IDX_OCR)
				oe_q <= {apb_req.pwdata[6], apb_req.pwdata[4], apb_req.pwdata[2], apb_req.pwdata[0]};
			if (wr && idx == IDX_CSR1)
				ie_q[1:0] <= apb_req.pwdata[1:0];
			if (wr && idx == IDX_CSR2)
				ie_q[2] <= apb_req.pwdata[4];
		end
	end
	a_ready_const: assert property (pready) else $error("ready low");
	a_err_access: assert property (pslverr |-> acc) else $error("error outside access");
	a_unmapped_read: assert property (acc && !apb_req.pwrite && !mapped
		|-> pslverr && prdata == 32'h0) else $error("unmapped read");
	a_reset_quiet: assert property (disable iff (1'b0) rst
		|=> pulse_output == 4'h0 && !irq_two) else $error("pins after reset");
	a_oe_gate: assert property ((pulse_output & ~$past(oe_q)) == 4'h0)
		else $error("disabled pin high");
	a_irq2_gate: assert property (irq_two |-> ie_q[2]) else $error("irq two masked");
	a_irq2_off: assert property (wr && idx == IDX_CSR2 && !apb_req.pwdata[4]
		|=> !irq_two) else $error("irq two stays");
	a_irq1_gate: assert property (irq_one |-> ie_q[1] || ie_q[0])
		else $error("irq one masked");
endmodule
`default_nettype wire

//--- sim/dart_load.sv
// Load model on the pins: measures high time and period
`default_nettype none
module dart_load
(
	input wire logic        ref_clk,    // Clock
	input wire logic        rst,        // Reset
	input wire logic [3:0]  pins,       // PWM pins
	output logic [3:0][12:0] high_len,  // Last high time
	output logic [3:0][12:0] period_len // Last rise to rise
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0][12:0] run_c;
	logic [3:0][12:0] hi_c;
	logic [3:0]       prev;
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			prev[i] <= pins[i] && !rst;
			if (pins[i] && !prev[i])
			begin
				period_len[i] <= run_c[i];
				run_c[i] <= 13'h001;
				hi_c[i] <= 13'h001;
			end
			else
			begin
				run_c[i] <= run_c[i] + 13'h001;
				if (pins[i])
					hi_c[i] <= hi_c[i] + 13'h001;
			end
			if (!pins[i] && prev[i])
				high_len[i] <= hi_c[i];
		end
	end
endmodule
`default_nettype wire

//--- sim/dart_top_tb.sv
// Self-checking bench for the dual autoreload timer
`default_nettype none
module dart_top_tb
	import dart_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [11:0] rel;
		logic [11:0] duty;
		logic [7:0]  csr;
		logic [7:0]  dtg;
		logic [12:0] hi;
		logic [12:0] per;
	} dart_row_t;
	logic             ref_clk;
	logic             rst;
	dart_apb_req_t    req;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             irq_one;
	logic             irq_two;
	logic [3:0]       pins;
	logic [3:0][12:0] hi_len;
	logic [3:0][12:0] per_len;
	logic [31:0]      rv;
	logic             ev;
	int               errors;
	int               n_compared;
	// High time is duty minus reload, less dead time, or period minus that when inverted; period 4096 minus reload
	dart_row_t rows [6] = '{
		'{12'hF00, 12'hF80, 8'h00, 8'h00, 13'h080, 13'h100},
		'{12'hFF0, 12'hFF8, 8'h00, 8'h00, 13'h008, 13'h010},
		'{12'hFFD, 12'hFFE, 8'h00, 8'h00, 13'h001, 13'h003},
		'{12'hFFE, 12'hFFF, 8'h00, 8'h00, 13'h001, 13'h002},
		'{12'hFF0, 12'hFF4, 8'h02, 8'h00, 13'h00C, 13'h010},
		'{12'hFF0, 12'hFF8, 8'h00, 8'h84, 13'h004, 13'h010}};
	dart_top dut (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pulse_output(pins), .irq_one(irq_one),
		.irq_two(irq_two));
	dart_load load (.ref_clk(ref_clk), .rst(rst), .pins(pins), .high_len(hi_len),
		.period_len(per_len));
	task give_verdict;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_len(input logic [12:0] got, input logic [12:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected length at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [5:0] i, input logic [7:0] d);
		req <= '{paddr: {i, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		@(posedge ref_clk);
		// Only the watchdog ends a wait for ready
		while (pready !== 1'b1)
			@(posedge ref_clk);
		rv = prdata;
		ev = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// Idle edge keeps two drives of psel out of one step
		@(posedge ref_clk);
	endtask
	task row(input dart_row_t r);
		bus(1'b1, IDX_ATR1H, {4'h0, r.rel[11:8]});
		bus(1'b1, IDX_ATR1L, r.rel[7:0]);
		bus(1'b1, IDX_DUTY0H, {4'h0, r.duty[11:8]});
		bus(1'b1, IDX_DUTY0H + 6'h1, r.duty[7:0]);
		bus(1'b1, IDX_CHCSR0, r.csr);
		bus(1'b1, IDX_DTG, r.dtg);
		bus(1'b1, IDX_CSR2, 8'h01);
		// First overflow under a new reload may be a full count away
		repeat (4096 + 3 * r.per + 20) @(posedge ref_clk);
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial
	begin
		#2000000;
		errors++;
		give_verdict;
	end
	initial
	begin
		errors = 0;
		n_compared = 0;
		req = '0;
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, IDX_CNT1L, 8'h00);
		chk(rv[7:0], 8'h00);
		bus(1'b0, IDX_CNT1L, 8'h00);
		chk(rv[7:0], 8'h03);
		bus(1'b0, IDX_CSR2, 8'h00);
		chk(rv[7:0], 8'h03);
		bus(1'b0, IDX_DTG, 8'h00);
		chk(rv[7:0], 8'h00);
		bus(1'b1, 6'h20, 8'hFF);
		bus(1'b0, 6'h20, 8'h00);
		chk({ev, rv[6:0]}, 8'h80);
		bus(1'b1, IDX_OCR, 8'h11);
		repeat (4100) @(posedge ref_clk);
		foreach (rows[k])
		begin
			row(rows[k]);
			chk_len(hi_len[0], rows[k].hi);
			chk_len(per_len[0], rows[k].per);
			bus(1'b0, IDX_CSR2, 8'h00);
			chk(rv[7:0], 8'h00);
		end
		bus(1'b1, IDX_DTG, 8'h00);
		bus(1'b1, IDX_DUTY0H + 6'h1, 8'hF2);
		repeat (60) @(posedge ref_clk);
		chk_len(hi_len[0], 13'h008);
		bus(1'b1, IDX_RELOAD_TWO_HIGH, 8'h0F);
		bus(1'b1, IDX_RELOAD_TWO_LOW, 8'hE0);
		bus(1'b1, IDX_DUTY0H + 6'h4, 8'h0F);
		bus(1'b1, IDX_DUTY0H + 6'h5, 8'hF0);
		bus(1'b1, IDX_CSR2, 8'h16);
		repeat (4400) @(posedge ref_clk);
		chk_len(per_len[2], 13'h020);
		chk_len(hi_len[2], 13'h010);
		chk_len(per_len[0], 13'h010);
		chk_len(hi_len[0], 13'h008);
		chk({7'h0, irq_two}, 8'h01);
		bus(1'b1, IDX_CSR2, 8'h10);
		bus(1'b0, IDX_CSR2, 8'h00);
		chk(rv[7:0], 8'h18);
		bus(1'b0, IDX_CSR2, 8'h00);
		chk(rv[7:0], 8'h10);
		chk({7'h0, irq_two}, 8'h00);
		bus(1'b1, IDX_CSR1, 8'h02);
		chk({7'h0, irq_one}, 8'h01);
		give_verdict;
	end
endmodule
bind dart_top dart_top_checker chk (.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_output(pulse_output),
	.irq_one(irq_one), .irq_two(irq_two));
`default_nettype wire
